// [design/cfg_word_mem.sv]
// Purpose: small word store holding the loaded configuration words
// Assumes: one write port and one read port on the same clock
// Notes: read data come out of a register one cycle after the address
`timescale 1ns/100ps

module cfg_word_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data_q
);

	initial begin
		if (DEPTH > (1 << AW) || DEPTH < 13 || WIDTH < 16) begin
			$error("cfg_word_mem: unsupported width or depth");
		end
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0] rd;
	} mem_s;

	mem_s q;
	mem_s d;

	always_comb begin
		d = q;
		if (wr_en && 32'(wr_addr) < DEPTH) begin
			d.mem[wr_addr] = wr_data;
		end
		d.rd = (32'(rd_addr) < DEPTH) ? q.mem[rd_addr] : '0;
	end

	// cleared store means unloaded fields read as zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rd_data_q = q.rd;

endmodule : cfg_word_mem

// [design/port_cfg_loader.sv]
// Purpose: fetch per-port configuration words after reset and serve the loaded register fields
// Assumes: the word fetch port is on ref_clk; config reads come from logic on ref_clk
// Notes: only the loaded fields are shown; all other register bits read as zero
`timescale 1ns/100ps
`include "port_cfg_regs.svh"

module port_cfg_loader #(
	parameter int NUM_WORDS = 13
) (
	input wire logic ref_clk,
	input wire logic rst,
	output logic rom_rd_req,
	output logic [7:0] rom_rd_addr,
	input wire logic rom_rd_valid,
	input wire logic [15:0] rom_rd_data,
	output logic load_done,
	output logic cfg_ready,
	input wire logic cfg_rd_req,
	input wire logic [2:0] cfg_rd_port,
	input wire logic [11:0] cfg_rd_offset,
	output logic cfg_rd_valid,
	output logic [31:0] cfg_rd_data
);

	initial begin
		if (NUM_WORDS != 13) begin
			$error("port_cfg_loader: word count must be 13");
		end
	end

	port_cfg_pkg::loader_s q;
	port_cfg_pkg::loader_s d;
	logic mem_wr;
	logic [3:0] mem_raddr;
	logic [15:0] mem_word;

	// ------------------------------------------------------------
	// source address of each stored word
	// ------------------------------------------------------------
	function automatic logic [7:0] word_addr(input logic [3:0] idx);
		logic [7:0] a;
		a = 8'h00;
		if (idx == `PCL_IDX_TC) begin
			a = `PCL_TC_ADDR;
		end else if (idx >= `PCL_IDX_PM_FIRST) begin
			a = 8'(`PCL_PM_BASE_ADDR + `PCL_WORD_STEP * 8'(idx - `PCL_IDX_PM_FIRST));
		end else begin
			a = 8'(`PCL_PB_BASE_ADDR + `PCL_WORD_STEP * 8'(idx));
		end
		return a;
	endfunction : word_addr

	// ------------------------------------------------------------
	// stored word that backs a register
	// ------------------------------------------------------------
	function automatic logic [3:0] word_index(input logic [11:0] off, input logic [2:0] port);
		logic [3:0] i;
		i = `PCL_IDX_PB_FIRST;
		case (off)
			`PCL_OFF_VGA, `PCL_OFF_PMCP, `PCL_OFF_VEND5: begin
				i = 4'(`PCL_IDX_PM_FIRST + 4'(port));
			end
			`PCL_OFF_TCMAP: begin
				i = `PCL_IDX_TC;
			end
			default: begin
				i = 4'(`PCL_IDX_PB_FIRST + 4'(port));
			end
		endcase
		return i;
	endfunction : word_index

	// ------------------------------------------------------------
	// place the word's fields into the register image
	// ------------------------------------------------------------
	function automatic logic [31:0] place(input logic [11:0] off, input logic [2:0] port,
		input logic [15:0] w);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (port < `PCL_NUM_PORTS) begin
			case (off)
				`PCL_OFF_PBDATA: begin
					r[`PCL_DST_BASEPWR] = w[`PCL_SRC_BASEPWR];
					r[`PCL_DST_SCALE] = w[`PCL_SRC_SCALE];
					r[`PCL_DST_PMSTATE] = w[`PCL_SRC_PMSTATE];
				end
				`PCL_OFF_PBCAP: begin
					r[`PCL_DST_SYSALLOC] = w[`PCL_SRC_SYSALLOC];
				end
				`PCL_OFF_PMCP: begin
					r[`PCL_DST_RXPOL] = w[`PCL_SRC_RXPOL];
					r[`PCL_DST_L0S] = w[`PCL_SRC_L0S];
					r[`PCL_DST_L1DLY] = w[`PCL_SRC_L1DLY];
					r[`PCL_DST_D3L1] = w[`PCL_SRC_D3L1];
				end
				`PCL_OFF_VGA: begin
					r[`PCL_DST_VGA] = w[`PCL_SRC_VGA];
				end
				`PCL_OFF_VEND5: begin
					r[`PCL_DST_VEND] = w[`PCL_SRC_VEND];
				end
				`PCL_OFF_TCMAP: begin
					// only the last port has its map loaded here
					if (port == `PCL_TC_PORT) begin
						r[`PCL_DST_TCMAP] = w[`PCL_SRC_TCMAP];
					end
				end
				default: begin
					r = 32'h0000_0000;
				end
			endcase
		end
		return r;
	endfunction : place

	// ------------------------------------------------------------
	// load sequencer and read pipeline
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		mem_wr = 1'b0;
		d.rd_req = 1'b0;
		case (q.st)
			port_cfg_pkg::ld_issue: begin
				d.rd_req = 1'b1;
				d.rd_addr = word_addr(q.idx);
				d.st = port_cfg_pkg::ld_wait;
			end
			port_cfg_pkg::ld_wait: begin
				if (rom_rd_valid) begin
					mem_wr = 1'b1;
					if (q.idx == `PCL_IDX_LAST) begin
						d.st = port_cfg_pkg::ld_done;
						d.done = 1'b1;
					end else begin
						d.idx = 4'(q.idx + 4'h1);
						d.st = port_cfg_pkg::ld_issue;
					end
				end
			end
			port_cfg_pkg::ld_done: begin
				d.done = 1'b1;
			end
			default: begin
				d.st = port_cfg_pkg::ld_issue;
				d.idx = `PCL_IDX_PB_FIRST;
				d.done = 1'b0;
			end
		endcase
		// reads before the load ends would show hardware defaults, so they are ignored
		d.s1_valid = cfg_rd_req && q.done;
		d.s1_off = cfg_rd_offset;
		d.s1_port = cfg_rd_port;
		d.out_valid = q.s1_valid;
		d.out_data = q.s1_valid ? place(q.s1_off, q.s1_port, mem_word) : q.out_data;
	end

	assign mem_raddr = word_index(cfg_rd_offset, cfg_rd_port);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	cfg_word_mem #(
		.WIDTH(16),
		.DEPTH(16),
		.AW(4)
	) u_mem (
		.ref_clk(ref_clk),
		.rst(rst),
		.wr_en(mem_wr),
		.wr_addr(q.idx),
		.wr_data(rom_rd_data),
		.rd_addr(mem_raddr),
		.rd_data_q(mem_word)
	);

	assign rom_rd_req = q.rd_req;
	assign rom_rd_addr = q.rd_addr;
	assign load_done = q.done;
	assign cfg_ready = q.done;
	assign cfg_rd_valid = q.out_valid;
	assign cfg_rd_data = q.out_data;

endmodule : port_cfg_loader

// [design/port_cfg_pkg.sv]
// Purpose: types shared by the port configuration word loader
// Assumes: nothing beyond the regs header
// Notes: state encodings are written out
package port_cfg_pkg;

	typedef enum logic [1:0] {
		ld_issue = 2'b00,
		ld_wait = 2'b01,
		ld_done = 2'b10
	} load_state_e;

	typedef struct packed {
		load_state_e st;
		logic [3:0] idx;
		logic done;
		logic rd_req;
		logic [7:0] rd_addr;
		logic s1_valid;
		logic [11:0] s1_off;
		logic [2:0] s1_port;
		logic out_valid;
		logic [31:0] out_data;
	} loader_s;

endpackage : port_cfg_pkg

// [design/port_cfg_regs.svh]
// Purpose: constants for the port configuration word loader
// Assumes: word addresses of the configuration store are 8 bits, offsets 12 bits
// Notes: bit-range macros expand to a part-select range such as 7:0
`ifndef PORT_CFG_REGS_SVH
`define PORT_CFG_REGS_SVH

// ------------------------------------------------------------
// source word addresses
// ------------------------------------------------------------
`define PCL_PB_BASE_ADDR 8'h70
`define PCL_PM_BASE_ADDR 8'h80
`define PCL_TC_ADDR 8'h6a
`define PCL_WORD_STEP 8'h02

// ------------------------------------------------------------
// word memory layout: 0..5 budget, 6..11 pm control, 12 tc map
// ------------------------------------------------------------
`define PCL_IDX_PB_FIRST 4'h0
`define PCL_IDX_PM_FIRST 4'h6
`define PCL_IDX_TC 4'hc
`define PCL_IDX_LAST 4'hc
`define PCL_TC_PORT 3'h5
`define PCL_NUM_PORTS 3'h6

// ------------------------------------------------------------
// configuration space offsets
// ------------------------------------------------------------
`define PCL_OFF_VGA 12'h070
`define PCL_OFF_PMCP 12'h074
`define PCL_OFF_VEND5 12'h088
`define PCL_OFF_TCMAP 12'h154
`define PCL_OFF_PBDATA 12'h214
`define PCL_OFF_PBCAP 12'h218

// ------------------------------------------------------------
// field positions: source word and destination register
// ------------------------------------------------------------
`define PCL_SRC_BASEPWR 7:0
`define PCL_DST_BASEPWR 7:0
`define PCL_SRC_SCALE 9:8
`define PCL_DST_SCALE 9:8
`define PCL_SRC_PMSTATE 11:10
`define PCL_DST_PMSTATE 14:13
`define PCL_SRC_SYSALLOC 15
`define PCL_DST_SYSALLOC 0
`define PCL_SRC_RXPOL 6
`define PCL_DST_RXPOL 14
`define PCL_SRC_L0S 5:4
`define PCL_DST_L0S 13:12
`define PCL_SRC_L1DLY 3:2
`define PCL_DST_L1DLY 11:10
`define PCL_SRC_D3L1 1:0
`define PCL_DST_D3L1 9:8
`define PCL_SRC_VGA 7
`define PCL_DST_VGA 31
`define PCL_SRC_VEND 15:8
`define PCL_DST_VEND 31:24
`define PCL_SRC_TCMAP 15:9
`define PCL_DST_TCMAP 7:1

`endif

// [testbench/cfg_store_model.sv]
// Purpose: behavioural config store answering word fetches
// Assumes: one word per request, answer after 1 or 5 cycles
// Notes: idle data lines toggle so stale words never look valid
`timescale 1ns/100ps
module cfg_store_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic [15:0] mask,
	input wire logic rom_rd_req,
	input wire logic [7:0] rom_rd_addr,
	output logic rom_rd_valid,
	output logic [15:0] rom_rd_data
);
	logic [2:0] wait_q;
	logic busy_q;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			busy_q <= 1'b0;
			wait_q <= 3'h0;
			rom_rd_valid <= 1'b0;
			rom_rd_data <= 16'h0;
		end else begin
			rom_rd_valid <= 1'b0;
			rom_rd_data <= ~rom_rd_data;
			if (rom_rd_req) begin
				busy_q <= 1'b1;
				wait_q <= slow ? 3'h4 : 3'h0;
			end else if (busy_q && wait_q != 3'h0) begin
				wait_q <= wait_q - 3'h1;
			end else if (busy_q) begin
				busy_q <= 1'b0;
				rom_rd_valid <= 1'b1;
				rom_rd_data <= {~rom_rd_addr, rom_rd_addr} ^ mask;
			end
		end
	end
endmodule : cfg_store_model

// [testbench/port_cfg_loader_checker.sv]
// Purpose: port checks on the config word loader
// Assumes: one clock, async reset high
// Notes: fetch order, completion and read latency
`timescale 1ns/100ps
module port_cfg_loader_checker (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic rom_rd_req,
	input wire logic [7:0] rom_rd_addr,
	input wire logic rom_rd_valid,
	input wire logic load_done,
	input wire logic cfg_ready,
	input wire logic cfg_rd_req,
	input wire logic cfg_rd_valid
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ----
	// fetch, completion and read latency
	// ----
	first_fetch_a: assert property ($fell(rst) |=> rom_rd_req && rom_rd_addr == 8'h70)
		else $error("first fetch wrong");
	req_pulse_a: assert property (rom_rd_req |=> !rom_rd_req)
		else $error("fetch request too long");
	// the word is taken on one edge, the issue state raises the next request on the edge after
	addr_step_a: assert property (rom_rd_valid && rom_rd_addr inside {[8'h70:8'h78], [8'h80:8'h88]}
		|-> ##2 rom_rd_req && rom_rd_addr == $past(rom_rd_addr, 2) + 8'h02) else $error("fetch step wrong");
	pm_start_a: assert property (rom_rd_valid && rom_rd_addr == 8'h7a |-> ##2 rom_rd_req && rom_rd_addr == 8'h80)
		else $error("control word fetch wrong");
	tc_fetch_a: assert property (rom_rd_valid && rom_rd_addr == 8'h8a |-> ##2 rom_rd_req && rom_rd_addr == 8'h6a)
		else $error("map word fetch wrong");
	done_last_a: assert property (rom_rd_valid && rom_rd_addr == 8'h6a |=> load_done && !rom_rd_req)
		else $error("done not after last word");
	done_hold_a: assert property (load_done |=> load_done && cfg_ready)
		else $error("done or ready dropped");
	read_answer_a: assert property (cfg_rd_req && cfg_ready |-> ##2 cfg_rd_valid)
		else $error("read answer late");
	no_early_a: assert property (cfg_rd_valid |-> $past(cfg_rd_req, 2) && $past(cfg_ready, 2))
		else $error("answer without request");
endmodule : port_cfg_loader_checker

bind port_cfg_loader port_cfg_loader_checker i_chk (.ref_clk, .rst, .rom_rd_req, .rom_rd_addr,
	.rom_rd_valid, .load_done, .cfg_ready, .cfg_rd_req, .cfg_rd_valid);

// [testbench/testbench.sv]
// Purpose: self-checking bench for the port config word loader
// Assumes: store model answers every fetch
// Notes: two loads, fast then slow with inverted words
`timescale 1ns/100ps
module testbench;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic slow = 1'b0;
	logic [15:0] mask = 16'h0;
	logic rom_rd_req, rom_rd_valid, load_done, cfg_ready, cfg_rd_valid;
	logic [7:0] rom_rd_addr;
	logic [15:0] rom_rd_data;
	logic cfg_rd_req = 1'b0;
	logic [2:0] cfg_rd_port = 3'h0;
	logic [11:0] cfg_rd_offset = 12'h0;
	logic [31:0] cfg_rd_data;
	int failures = 0;
	int num_checks = 0;
	logic [11:0] offs [7] = '{12'h070, 12'h074, 12'h088, 12'h154, 12'h214, 12'h218, 12'h07c};
	always #2.5 ref_clk = ~ref_clk;
	port_cfg_loader i_dut (.ref_clk, .rst, .rom_rd_req, .rom_rd_addr, .rom_rd_valid, .rom_rd_data, .load_done,
		.cfg_ready, .cfg_rd_req, .cfg_rd_port, .cfg_rd_offset, .cfg_rd_valid, .cfg_rd_data);
	cfg_store_model i_store (.ref_clk, .rst, .slow, .mask, .rom_rd_req, .rom_rd_addr, .rom_rd_valid, .rom_rd_data);
	// ----
	// checks
	// ----
	function automatic logic [15:0] w(input logic [7:0] a);
		return {~a, a} ^ mask;
	endfunction : w
	function automatic logic [31:0] expect_rd(input logic [2:0] p, input logic [11:0] o);
		logic [15:0] b;
		logic [15:0] m;
		logic [15:0] t;
		b = w(8'h70 + {4'h0, p, 1'b0});
		m = w(8'h80 + {4'h0, p, 1'b0});
		t = w(8'h6a);
		if (p > 3'h5) return 32'h0;
		case (o)
			12'h214: return {17'h0, b[11:10], 3'h0, b[9:0]};
			12'h218: return {31'h0, b[15]};
			12'h074: return {17'h0, m[6:0], 8'h0};
			12'h070: return {m[7], 31'h0};
			12'h088: return {m[15:8], 24'h0};
			12'h154: return p == 3'h5 ? {24'h0, t[15:9], 1'b0} : 32'h0;
			default: return 32'h0;
		endcase
	endfunction : expect_rd
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	// reads held up during the load must vanish, not queue
	task automatic load(input logic s, input logic [15:0] k);
		int n;
		rst = 1'b1;
		slow = s;
		mask = k;
		repeat (6) @(posedge ref_clk);
		chk("reset done", 32'h0, {31'h0, load_done});
		#1 rst = 1'b0;
		cfg_rd_req = 1'b1;
		n = 0;
		while (load_done !== 1'b1 && n < 400) begin
			@(posedge ref_clk);
			#1 n++;
			chk("early valid", 32'h0, {31'h0, cfg_rd_valid});
		end
		cfg_rd_req = 1'b0;
		// a load that never ends counts here and again at the ready check; the run still goes on to the one verdict
		if (n == 400) begin
			failures++;
		end
		chk("ready", 32'h1, {31'h0, cfg_ready});
	endtask : load
	// back-to-back reads over every port and offset
	task automatic sweep();
		logic [31:0] e [$];
		for (int i = 0; i < 58; i++) begin
			@(posedge ref_clk);
			#1;
			if (i >= 2) begin
				chk("valid", 32'h1, {31'h0, cfg_rd_valid});
				chk("data", e.pop_front(), cfg_rd_data);
			end
			cfg_rd_req = i < 56;
			cfg_rd_port = 3'(i / 7);
			cfg_rd_offset = offs[i % 7];
			e.push_back(expect_rd(3'(i / 7), offs[i % 7]));
		end
		cfg_rd_req = 1'b0;
	endtask : sweep
	initial begin
		load(1'b0, 16'h0000);
		sweep();
		load(1'b1, 16'hffff);
		sweep();
		stop_test();
	end
endmodule : testbench
